// ### cip_pkg.sv
// Constants for the configurable I/O port bank: register offsets, lane masks
// per port, reset values. Assumes ports A..D sit in byte lanes 0..3 of a
// 32-bit flat pin vector, port A in bits 7:0.

package cip_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W   = 8;
  localparam int PORT_W   = 8;
  localparam int BANK_W   = 32;
  localparam int CELL_W   = 24;

  // ****************************************************************
  // Register offsets within the I/O window (port index added, 0..3)
  // ****************************************************************
  localparam logic [7:0] REG_PIN_INPUT      = 8'h00;
  localparam logic [7:0] REG_OUTPUT_LATCH   = 8'h04;
  localparam logic [7:0] REG_PIN_DIRECTION  = 8'h08;
  localparam logic [7:0] REG_DRIVE_SELECT   = 8'h0c;
  localparam logic [7:0] REG_MODE_CONTROL   = 8'h10;
  localparam logic [7:0] REG_CELL_ACCESS    = 8'h14;
  localparam logic [7:0] REG_CELL_MASK      = 8'h18;
  localparam logic [7:0] REG_INPUT_CELL     = 8'h1c;
  localparam logic [7:0] REG_DRIVER_ENABLE  = 8'h20;
  localparam logic [7:0] REG_MEM_MAP_CONFIG = 8'h24;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          PIO_ENABLE_BIT = 7;
  localparam logic [31:0] PCR_RESET      = 32'h0000_0000;
  localparam logic [31:0] LATCH_RESET    = 32'h0000_0000;
  localparam logic [7:0]  MAP_RESET      = 8'h00;

  // ****************************************************************
  // Lane masks: which bits exist for each register kind
  // ****************************************************************
  localparam logic [31:0] PIN_MASK       = 32'h07ff_ffff;
  localparam logic [31:0] CONTROL_MASK   = 32'h0000_ffff;
  localparam logic [31:0] CELL_MASK      = 32'h00ff_ffff;
  localparam logic [31:0] OPEN_DRAIN_CAP = 32'h00ff_f0f0;
  localparam logic [31:0] FAST_SLEW_CAP  = 32'h0700_0f0f;
  localparam logic [31:0] DRIVE_MASK     = 32'h07ff_ffff;

endpackage

// ### cip_port_bank.sv
// Configurable I/O port bank: four ports of pin logic plus the per-port
// configuration and data registers seen by the microcontroller.
// Assumes the microcontroller bus signals are already on clk_in; pins and
// the address latch strobe are asynchronous and are synchronised here.

`timescale 1ns/100ps

module cip_port_bank
  import cip_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                resetn_in,
  // Microcontroller bus
  input  wire logic                io_window_sel_in,
  input  wire logic [ADDR_W-1:0]   mcu_addr_in,
  input  wire logic                mcu_rd_in,
  input  wire logic                mcu_wr_in,
  input  wire logic [PORT_W-1:0]   mcu_data_in,
  output logic      [PORT_W-1:0]   mcu_data_out,
  output logic                     mcu_data_oe_out,
  // Port A bus modes
  input  wire logic                data_port_mode_in,
  input  wire logic                peripheral_select_a_in,
  input  wire logic                peripheral_select_b_in,
  output logic                     peripheral_io_mode_out,
  // Pins, port A in bits 7:0 up to port D in bits 26:24
  input  wire logic [BANK_W-1:0]   pin_in,
  output logic      [BANK_W-1:0]   pin_out,
  output logic      [BANK_W-1:0]   pin_oe_out,
  output logic      [BANK_W-1:0]   pin_open_drain_out,
  output logic      [BANK_W-1:0]   pin_fast_slew_out,
  // General logic array side
  input  wire logic [BANK_W-1:0]   oe_term_in,
  input  wire logic [BANK_W-1:0]   pld_route_in,
  input  wire logic [BANK_W-1:0]   pld_value_in,
  input  wire logic [CELL_W-1:0]   cell_next_in,
  input  wire logic [CELL_W-1:0]   cell_en_in,
  input  wire logic [CELL_W-1:0]   input_latch_sel_in,
  output logic      [CELL_W-1:0]   cell_value_out,
  output logic      [CELL_W-1:0]   input_cell_out,
  // Memory decode array side
  input  wire logic [BANK_W-1:0]   decode_use_in,
  output logic      [BANK_W-1:0]   decode_addr_out,
  // Latched address for address-out mode
  input  wire logic [PORT_W-1:0]   addr_out_a_in,
  input  wire logic [PORT_W-1:0]   addr_out_b_in,
  input  wire logic                address_latch_strobe_in,
  // Programming interface sharing port C
  input  wire logic                jtag_en_in,
  input  wire logic [PORT_W-1:0]   jtag_out_in,
  input  wire logic [PORT_W-1:0]   jtag_oe_in
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [BANK_W-1:0] mode_control;
  logic [BANK_W-1:0] pin_direction;
  logic [BANK_W-1:0] drive_select;
  logic [BANK_W-1:0] output_latch;
  logic [BANK_W-1:0] cell_mask;
  logic [7:0]        mem_map_config;
  logic [BANK_W-1:0] pin_meta;
  logic [BANK_W-1:0] pin_sync;
  logic              strobe_meta;
  logic              strobe_sync;
  logic              strobe_prev;
  logic              wr_hit;
  logic              rd_hit;
  logic [7:0]        reg_kind;
  logic [1:0]        reg_port;
  logic              port_a_bus;
  logic              port_a_cut;
  logic [BANK_W-1:0] next_oe;
  logic [BANK_W-1:0] next_val;
  logic [BANK_W-1:0] open_drain;
  logic [BANK_W-1:0] addr_src;
  logic [BANK_W-1:0] pld_src;
  logic [7:0]        next_rdata;

  // Replace one byte lane, then drop bits that do not exist
  function automatic logic [BANK_W-1:0] put_lane(input logic [BANK_W-1:0] cur,
                                                 input logic [1:0]        port,
                                                 input logic [7:0]        data,
                                                 input logic [BANK_W-1:0] mask);
    logic [BANK_W-1:0] lane;
    logic [BANK_W-1:0] wide;
    lane = 32'h0000_00ff << {port, 3'b000};
    wide = {24'h00_0000, data} << {port, 3'b000};
    return ((cur & ~lane) | (wide & lane)) & mask;
  endfunction

  // Pick one byte lane of a bank vector
  function automatic logic [7:0] get_lane(input logic [BANK_W-1:0] v,
                                          input logic [1:0]        port);
    return v[{port, 3'b000} +: 8];
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Plain read and write cycles inside the I/O window
  assign wr_hit   = io_window_sel_in & mcu_wr_in;
  assign rd_hit   = io_window_sel_in & mcu_rd_in;
  assign reg_kind = {mcu_addr_in[7:2], 2'b00};
  assign reg_port = mcu_addr_in[1:0];

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins and strobe are asynchronous; two flops before any use
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_meta    <= 32'h0000_0000;
      pin_sync    <= 32'h0000_0000;
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_prev <= 1'b0;
    end else begin
      pin_meta    <= pin_in;
      pin_sync    <= pin_meta;
      strobe_meta <= address_latch_strobe_in;
      strobe_sync <= strobe_meta;
      strobe_prev <= strobe_sync;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Per-pin control, direction and drive select, all cleared at reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_control  <= PCR_RESET;
      pin_direction <= PCR_RESET;
      drive_select  <= PCR_RESET;
    end else if (wr_hit) begin
      if (reg_kind == REG_MODE_CONTROL) begin
        mode_control <= put_lane(mode_control, reg_port, mcu_data_in,
                                 CONTROL_MASK);
      end
      if (reg_kind == REG_PIN_DIRECTION) begin
        pin_direction <= put_lane(pin_direction, reg_port, mcu_data_in,
                                  PIN_MASK);
      end
      if (reg_kind == REG_DRIVE_SELECT) begin
        drive_select <= put_lane(drive_select, reg_port, mcu_data_in,
                                 DRIVE_MASK);
      end
    end
  end

  // Output data latch and output cell load mask
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      output_latch <= LATCH_RESET;
      cell_mask    <= PCR_RESET;
    end else if (wr_hit) begin
      if (reg_kind == REG_OUTPUT_LATCH) begin
        output_latch <= put_lane(output_latch, reg_port, mcu_data_in,
                                 PIN_MASK);
      end
      if (reg_kind == REG_CELL_MASK) begin
        cell_mask <= put_lane(cell_mask, reg_port, mcu_data_in, CELL_MASK);
      end
    end
  end

  // Memory mapping config; only the peripheral mode bit is kept here
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_map_config <= MAP_RESET;
    end else if (wr_hit && reg_kind == REG_MEM_MAP_CONFIG && reg_port == 2'd0) begin
      mem_map_config <= mcu_data_in & (8'h01 << PIO_ENABLE_BIT);
    end
  end

  // ****************************************************************
  // Output cells
  // ****************************************************************
  // A bus write wins over the logic array's own clock enable,
  // except where the mask holds the flop for the array alone
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cell_value_out <= 24'h00_0000;
    end else begin
      for (int i = 0; i < CELL_W; i++) begin
        if (wr_hit && reg_kind == REG_CELL_ACCESS && reg_port == 2'(i / 8)
            && !cell_mask[i]) begin
          cell_value_out[i] <= mcu_data_in[i % 8];
        end else if (cell_en_in[i]) begin
          cell_value_out[i] <= cell_next_in[i];
        end
      end
    end
  end

  // ****************************************************************
  // Input cells and address inputs
  // ****************************************************************
  // Selected bits hold the pin level taken at the strobe's rising
  // edge; the rest follow the pin, so high address bits may be latched
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      input_cell_out <= 24'h00_0000;
    end else begin
      for (int i = 0; i < CELL_W; i++) begin
        if (!input_latch_sel_in[i]) begin
          input_cell_out[i] <= pin_sync[i];
        end else if (strobe_sync && !strobe_prev) begin
          input_cell_out[i] <= pin_sync[i];
        end
      end
    end
  end

  // Any input used by the memory decode is handed over as address;
  // port D has no input cells, so its pins go across directly
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      decode_addr_out <= 32'h0000_0000;
    end else begin
      decode_addr_out <= decode_use_in & PIN_MASK &
                         {pin_sync[31:24], input_cell_out};
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Either bus mode owns port A, selected or not
  assign port_a_cut = data_port_mode_in | mem_map_config[PIO_ENABLE_BIT];
  assign port_a_bus = data_port_mode_in |
                      (mem_map_config[PIO_ENABLE_BIT] &
                       (peripheral_select_a_in | peripheral_select_b_in));
  assign addr_src   = {16'h0000, addr_out_b_in, addr_out_a_in};
  assign pld_src    = {pld_value_in[31:24], cell_value_out};
  assign open_drain = drive_select & OPEN_DRAIN_CAP;

  // Source and enable per pin before the driver stage
  always_comb begin
    next_oe  = (pin_direction | oe_term_in) & PIN_MASK;
    next_val = output_latch;
    for (int i = 0; i < BANK_W; i++) begin
      if (mode_control[i]) begin
        next_val[i] = addr_src[i];
      end else if (pld_route_in[i]) begin
        next_val[i] = pld_src[i];
      end
    end
    // Bus modes take port A whole; general I/O is cut off, and the
    // peripheral buffer floats while neither select is active
    if (port_a_cut) begin
      next_oe[7:0]  = {8{mcu_wr_in & port_a_bus}};
      next_val[7:0] = mcu_data_in;
    end
    // Programming only happens outside normal operation
    if (jtag_en_in) begin
      next_oe[23:16]  = jtag_oe_in;
      next_val[23:16] = jtag_out_in;
    end
  end

  // Driver stage; open drain only ever pulls low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_out            <= 32'h0000_0000;
      pin_oe_out         <= 32'h0000_0000;
      pin_open_drain_out <= 32'h0000_0000;
      pin_fast_slew_out  <= 32'h0000_0000;
    end else begin
      pin_out            <= next_val & ~open_drain;
      pin_oe_out         <= next_oe & ~(open_drain & next_val);
      pin_open_drain_out <= open_drain;
      pin_fast_slew_out  <= drive_select & FAST_SLEW_CAP;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unmapped offsets and absent lanes read as zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_kind)
      REG_PIN_INPUT:      next_rdata = get_lane(pin_sync & PIN_MASK, reg_port);
      REG_OUTPUT_LATCH:   next_rdata = get_lane(output_latch, reg_port);
      REG_PIN_DIRECTION:  next_rdata = get_lane(pin_direction, reg_port);
      REG_DRIVE_SELECT:   next_rdata = get_lane(drive_select, reg_port);
      REG_MODE_CONTROL:   next_rdata = get_lane(mode_control, reg_port);
      REG_CELL_ACCESS:    next_rdata = get_lane({8'h00, cell_value_out}, reg_port);
      REG_CELL_MASK:      next_rdata = get_lane(cell_mask, reg_port);
      REG_INPUT_CELL:     next_rdata = get_lane({8'h00, input_cell_out}, reg_port);
      REG_DRIVER_ENABLE:  next_rdata = get_lane(pin_oe_out & CELL_MASK, reg_port);
      REG_MEM_MAP_CONFIG: next_rdata = (reg_port == 2'd0) ? mem_map_config : 8'h00;
      default:            next_rdata = 8'h00;
    endcase
  end

  // Bus answer; port A pins come back through the synchroniser
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mcu_data_out    <= 8'h00;
      mcu_data_oe_out <= 1'b0;
    end else begin
      if (rd_hit) begin
        mcu_data_out <= next_rdata;
      end else if (port_a_bus && mcu_rd_in) begin
        mcu_data_out <= pin_sync[7:0];
      end
      mcu_data_oe_out <= rd_hit | (port_a_bus & mcu_rd_in);
    end
  end

  // Peripheral mode flag mirrored from its register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      peripheral_io_mode_out <= 1'b0;
    end else begin
      peripheral_io_mode_out <= mem_map_config[PIO_ENABLE_BIT];
    end
  end

endmodule // cip_port_bank

// ### cip_port_bank_sva.sv
// Checker for the port bank: bus answers, pin drive and mode relations.
// Assumes it is bound to cip_port_bank and sees only its ports.
`timescale 1ns/100ps
module cip_port_bank_sva
  import cip_pkg::*;
(
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              resetn_in,
  // Microcontroller bus
  input wire logic              io_window_sel_in,
  input wire logic [ADDR_W-1:0] mcu_addr_in,
  input wire logic              mcu_rd_in,
  input wire logic              mcu_wr_in,
  input wire logic [PORT_W-1:0] mcu_data_in,
  input wire logic [PORT_W-1:0] mcu_data_out,
  input wire logic              mcu_data_oe_out,
  // Port A bus modes
  input wire logic              data_port_mode_in,
  input wire logic              peripheral_select_a_in,
  input wire logic              peripheral_select_b_in,
  input wire logic              peripheral_io_mode_out,
  // Pins and terms
  input wire logic [BANK_W-1:0] pin_in,
  input wire logic [BANK_W-1:0] pin_out,
  input wire logic [BANK_W-1:0] pin_oe_out,
  input wire logic [BANK_W-1:0] pin_open_drain_out,
  input wire logic [BANK_W-1:0] pin_fast_slew_out,
  input wire logic [BANK_W-1:0] oe_term_in
);
  // ****
  // Sequences
  // ****
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence bus_wr(logic [7:0] a);
    io_window_sel_in && mcu_wr_in && mcu_addr_in == a;
  endsequence
  sequence bus_rd(logic [7:0] a);
    io_window_sel_in && mcu_rd_in && mcu_addr_in == a;
  endsequence
  // Port C quiet long enough to pass both sync flops
  sequence pins_c_quiet;
    $stable(pin_in[23:16]) [*4];
  endsequence
  // ****
  // Assertions
  // ****
  chk_read_answer: assert property (io_window_sel_in && mcu_rd_in |=> mcu_data_oe_out)
    else $error("read not answered");
  chk_bus_idle: assert property (!mcu_rd_in |=> !mcu_data_oe_out)
    else $error("bus driven without read");
  chk_periph_on: assert property (bus_wr(REG_MEM_MAP_CONFIG) ##0 mcu_data_in[7] |-> ##[1:2] peripheral_io_mode_out)
    else $error("peripheral mode not entered");
  chk_periph_tristate: assert property ((peripheral_io_mode_out && !data_port_mode_in && !peripheral_select_a_in && !peripheral_select_b_in) [*3] |-> pin_oe_out[7:0] == 8'h00)
    else $error("port A driven without select");
  chk_data_port: assert property ((data_port_mode_in && !mcu_wr_in) [*3] |-> pin_oe_out[7:0] == 8'h00)
    else $error("port A general drive in data mode");
  chk_od_low: assert property ((pin_out & pin_open_drain_out) == 32'h0)
    else $error("open drain pin driven high");
  chk_drive_caps: assert property (((pin_open_drain_out & ~OPEN_DRAIN_CAP) | (pin_fast_slew_out & ~FAST_SLEW_CAP)) == 32'h0)
    else $error("drive select on wrong pin");
  chk_unused_pins: assert property (pin_oe_out[31:27] == 5'h00)
    else $error("absent pin driven");
  chk_dir_to_pin: assert property (bus_wr(REG_PIN_DIRECTION + 8'h03) ##0 mcu_data_in[2:0] == 3'h7 |-> ##2 pin_oe_out[26:24] == 3'h7)
    else $error("direction write not on pins");
  chk_term_drives: assert property ((oe_term_in[26:24] == 3'h7) [*3] |-> pin_oe_out[26:24] == 3'h7)
    else $error("enable term ignored");
  chk_dir_d_read: assert property (bus_rd(REG_PIN_DIRECTION + 8'h03) |=> mcu_data_out[7:3] == 5'h00)
    else $error("unused direction bits read back");
  chk_pin_read: assert property (pins_c_quiet ##0 bus_rd(REG_PIN_INPUT + 8'h02) |=> mcu_data_out == $past(pin_in[23:16]))
    else $error("data in differs from pins");
endmodule // cip_port_bank_sva

bind cip_port_bank cip_port_bank_sva u_sva (.*);

// ### cip_mcu_model.sv
// Microcontroller model: plain read and write cycles into the I/O window.
// Assumes the bank takes a request at a rising edge and holds its answer.
`timescale 1ns/100ps
module cip_mcu_model
  import cip_pkg::*;
(
  // Clock and answer
  input  wire logic              clk_in,
  input  wire logic [PORT_W-1:0] rd_data_in,
  // Bus request
  output logic                   sel_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   rd_out,
  output logic                   wr_out,
  output logic [PORT_W-1:0]      data_out
);
  // Idle bus at time zero
  initial begin
    {sel_out, rd_out, wr_out} = 3'h0;
    addr_out = 8'h00;
    data_out = 8'h00;
  end
  // Launched after an edge, held over the taking edge
  task automatic cycle(input logic r, input logic [7:0] a, x);
    @(posedge clk_in);
    sel_out  <= 1'b1;
    rd_out   <= r;
    wr_out   <= !r;
    addr_out <= a;
    data_out <= x;
    @(posedge clk_in);
    sel_out  <= 1'b0;
    rd_out   <= 1'b0;
    wr_out   <= 1'b0;
    addr_out <= ~a; // Released lines never keep the last value
    data_out <= ~x;
  endtask
  // Answer holds until the next read, so mid-cycle is safe
  task automatic read(input logic [7:0] a, output logic [7:0] q);
    cycle(1'b1, a, 8'h00);
    @(posedge clk_in);
    @(negedge clk_in);
    q = rd_data_in;
  endtask
endmodule // cip_mcu_model

// ### test_configurable_io_port_bank.sv
// Self-checking bench for the port bank: registers, pins, cells, modes.
// Assumes the bus model is the only master; pin levels resolve here.
`timescale 1ns/100ps
module test_configurable_io_port_bank;
  import cip_pkg::*;
  logic              clk_in, resetn_in, sel, rd, wr, doe, pmode, dpm, psa, psb, jen, als;
  logic [7:0]        addr, wdat, rdat, jo, d, l, t, e, o, m, v;
  logic [31:0]       pins, oet, dec, old, seed;
  logic [BANK_W-1:0] pin_in, pin_out, pin_oe_out, od, fs, dad;
  logic [23:0]       ils, cell_v, cell_i;
  int                fails, compares;
  // Driven bits win over the outside world
  assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & pins);
  cip_mcu_model u_mcu (.clk_in(clk_in), .rd_data_in(rdat), .sel_out(sel), .addr_out(addr),
    .rd_out(rd), .wr_out(wr), .data_out(wdat));
  cip_port_bank dut (.clk_in(clk_in), .resetn_in(resetn_in), .io_window_sel_in(sel),
    .mcu_addr_in(addr), .mcu_rd_in(rd), .mcu_wr_in(wr), .mcu_data_in(wdat),
    .mcu_data_out(rdat), .mcu_data_oe_out(doe), .data_port_mode_in(dpm),
    .peripheral_select_a_in(psa), .peripheral_select_b_in(psb),
    .peripheral_io_mode_out(pmode), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .pin_open_drain_out(od), .pin_fast_slew_out(fs),
    .oe_term_in(oet), .pld_route_in(32'h0), .pld_value_in(32'h0), .cell_next_in(24'h0),
    .cell_en_in(24'h0), .input_latch_sel_in(ils), .cell_value_out(cell_v),
    .input_cell_out(cell_i), .decode_use_in(dec), .decode_addr_out(dad),
    .addr_out_a_in(jo), .addr_out_b_in(~jo), .address_latch_strobe_in(als),
    .jtag_en_in(jen), .jtag_out_in(jo), .jtag_oe_in(jo));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] lane(logic [31:0] x, int p);
    return x[p*8 +: 8];
  endfunction
  // Readback of a plain register: only bits that exist survive
  function automatic logic [7:0] rw_exp(logic [7:0] k, int p, logic [7:0] x);
    return x & lane((k == REG_MODE_CONTROL) ? CONTROL_MASK : (k == REG_CELL_MASK) ?
      CELL_MASK : (k == REG_DRIVE_SELECT) ? DRIVE_MASK : PIN_MASK, p);
  endfunction
  task automatic check(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, x);
    logic [7:0] r;
    u_mcu.read(a, r);
    check({24'h0, r}, {24'h0, x});
  endtask
  // Register to pins takes two edges; a third for margin
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ****
  // Clock, watchdog, scenarios
  // ****
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Run needs a few hundred cycles; this allows fifty thousand
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    {resetn_in, dpm, psa, psb, jen, als} = 6'h00;
    {pins, oet, ils, jo, fails, compares} = '0;
    seed = 32'h0000_0044;
    dec = rnd();
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      chk_reg(REG_PIN_DIRECTION + 8'(p), 8'h00);
      chk_reg(REG_DRIVE_SELECT + 8'(p), 8'h00);
      chk_reg(REG_MODE_CONTROL + 8'(p), 8'h00);
      chk_reg(REG_CELL_MASK + 8'(p), 8'h00);
    end
    for (int i = 0; i < 32; i++) begin
      t = (i % 4 == 0) ? REG_PIN_DIRECTION : (i % 4 == 1) ? REG_DRIVE_SELECT :
        (i % 4 == 2) ? REG_MODE_CONTROL : REG_CELL_MASK;
      v = (i < 4 || i == 12) ? 8'hff : 8'(rnd());
      u_mcu.cycle(1'b0, t + 8'(i % 16 / 4), v);
      chk_reg(t + 8'(i % 16 / 4), rw_exp(t, i % 16 / 4, v));
    end
    u_mcu.cycle(1'b0, 8'h25, 8'hff);
    chk_reg(8'h25, 8'h00);
    chk_reg(8'h3c, 8'h00);
    for (int p = 0; p < 4; p++)
      u_mcu.cycle(1'b0, REG_DRIVE_SELECT + 8'(p), 8'hff);
    settle();
    check(od, OPEN_DRAIN_CAP);
    check(fs, FAST_SLEW_CAP);
    for (int p = 0; p < 4; p++) begin
      d = 8'(rnd());
      l = 8'(rnd());
      t = 8'(rnd()) | ((p == 3) ? 8'h07 : 8'h00);
      u_mcu.cycle(1'b0, REG_DRIVE_SELECT + 8'(p), 8'h00);
      u_mcu.cycle(1'b0, REG_MODE_CONTROL + 8'(p), 8'h00);
      u_mcu.cycle(1'b0, REG_PIN_DIRECTION + 8'(p), d);
      u_mcu.cycle(1'b0, REG_OUTPUT_LATCH + 8'(p), l);
      oet[p*8 +: 8] <= t;
      settle();
      e = (d | t) & lane(PIN_MASK, p);
      check({24'h0, pin_oe_out[p*8 +: 8]}, {24'h0, e});
      check({24'h0, pin_out[p*8 +: 8] & e}, {24'h0, l & e});
      if (p < 3) begin
        chk_reg(REG_DRIVER_ENABLE + 8'(p), e);
        chk_reg(REG_OUTPUT_LATCH + 8'(p), l);
      end
    end
    // Address-out on port B shows the latched address lane
    u_mcu.cycle(1'b0, REG_MODE_CONTROL + 8'h01, 8'hff);
    settle();
    check({24'h0, pin_out[15:8]}, {24'h0, ~jo});
    for (int p = 0; p < 4; p++)
      u_mcu.cycle(1'b0, REG_PIN_DIRECTION + 8'(p), 8'h00);
    oet <= 32'h0;
    pins <= rnd();
    repeat (5) @(posedge clk_in);
    for (int p = 0; p < 4; p++)
      chk_reg(REG_PIN_INPUT + 8'(p), lane(pins & PIN_MASK, p));
    check(dad, dec & pins & PIN_MASK);
    for (int p = 0; p < 3; p++) begin
      chk_reg(REG_INPUT_CELL + 8'(p), lane(pins, p));
      o = 8'(rnd());
      m = 8'(rnd());
      v = 8'(rnd());
      u_mcu.cycle(1'b0, REG_CELL_MASK + 8'(p), 8'h00);
      u_mcu.cycle(1'b0, REG_CELL_ACCESS + 8'(p), o);
      u_mcu.cycle(1'b0, REG_CELL_MASK + 8'(p), m);
      u_mcu.cycle(1'b0, REG_CELL_ACCESS + 8'(p), v);
      chk_reg(REG_CELL_ACCESS + 8'(p), (o & m) | (v & ~m));
      check({24'h0, cell_v[p*8 +: 8]}, {24'h0, (o & m) | (v & ~m)});
    end
    // Strobe latches the cells; later pin changes must not show
    @(posedge clk_in);
    ils <= 24'hff_ffff;
    als <= 1'b1;
    repeat (5) @(posedge clk_in);
    old = pins;
    pins <= ~pins;
    als <= 1'b0;
    repeat (5) @(posedge clk_in);
    for (int p = 0; p < 3; p++)
      chk_reg(REG_INPUT_CELL + 8'(p), lane(old, p));
    // Port A set to drive; peripheral mode must still float it
    u_mcu.cycle(1'b0, REG_PIN_DIRECTION, 8'hff);
    u_mcu.cycle(1'b0, REG_MEM_MAP_CONFIG, 8'h80);
    settle();
    check({31'h0, pmode}, 32'h1);
    check({24'h0, pin_oe_out[7:0]}, 32'h0);
    @(posedge clk_in);
    {psa, psb} <= 2'h3;
    repeat (6) @(posedge clk_in);
    {psa, psb, dpm} <= 3'h1;
    repeat (6) @(posedge clk_in);
    {dpm, jen} <= 2'h1;
    jo <= 8'(rnd());
    settle();
    check({24'h0, pin_oe_out[23:16]}, {24'h0, jo});
    give_verdict();
  end
endmodule // test_configurable_io_port_bank
